// ### design/pppc_ctrl.sv
// Power-up program policy controller
`timescale 1ns/1ps
module pppc_ctrl (
	// Clock and power-up reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Configuration options
	input wire pppc_pkg::pppc_opts_s opts_i,
	input wire logic [2:0] spi_rate_sel_i,
	input wire logic spi_clock_polarity_i,
	input wire logic spi_clock_phase_i,
	// Device state
	input wire logic test_reset_i,
	input wire logic programmed_i,
	input wire logic prog_interrupted_i,
	input wire logic [pppc_pkg::VER_W-1:0] floor_ver_i,
	input wire logic [pppc_pkg::VER_W-1:0] image_ver_i,
	input wire logic image_valid_i,
	// Programming requests
	input wire logic prog_req_i,
	input wire logic prog_master_i,
	input wire logic prog_erase_i,
	input wire logic [pppc_pkg::VER_W-1:0] prog_ver_i,
	input wire logic [pppc_pkg::SIG_W-1:0] prog_sig_i,
	input wire logic prog_sec_i,
	// Outputs
	output logic [pppc_pkg::VER_W-1:0] design_ver_o,
	output logic [pppc_pkg::SIG_W-1:0] signature_o,
	output logic sec_locked_o,
	output pppc_pkg::pppc_gate_s gate_o,
	output pppc_pkg::pppc_spi_s spi_o,
	output logic spi_clk_en_o,
	output logic update_start_o,
	output logic recover_start_o,
	output logic prog_accept_o,
	output logic prog_reject_o,
	output logic decided_o
);
	import pppc_pkg::*;

	pppc_state_e state_reg;
	logic [7:0] settle_reg;
	logic tr_meta_reg;
	logic tr_sync_reg;
	logic [7:0] div_cnt_reg;
	logic recovery_eff;
	logic otp_locked_reg;

	function automatic logic ver_newer(input logic [VER_W-1:0] a, input logic [VER_W-1:0] b);
		ver_newer = a > b;
	endfunction

	function automatic logic [7:0] rate_div(input logic [2:0] sel);
		unique case (sel)
			3'h0: rate_div = DIV_1M00;
			3'h1: rate_div = DIV_2M08;
			3'h2: rate_div = DIV_3M13;
			3'h3: rate_div = DIV_4M16;
			3'h4: rate_div = DIV_5M00;
			3'h5: rate_div = DIV_6M25;
			3'h6: rate_div = DIV_8M30;
			3'h7: rate_div = DIV_12M5;
		endcase
	endfunction

	assign recovery_eff = opts_i.recovery | opts_i.auto_update;

	// Test reset crosses in from a pin
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tr_meta_reg <= 1'b0;
			tr_sync_reg <= 1'b0;
		end else begin
			tr_meta_reg <= test_reset_i;
			tr_sync_reg <= tr_meta_reg;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_reg <= PPPC_ST_SETTLE;
			settle_reg <= 8'h00;
		end else begin
			unique case (state_reg)
				PPPC_ST_SETTLE: begin
					settle_reg <= settle_reg + 8'h01;
					if (settle_reg == 8'(SETTLE_CYC - 1)) begin
						state_reg <= PPPC_ST_DECIDE;
					end
				end
				PPPC_ST_DECIDE: begin
					if (recovery_eff && prog_interrupted_i) begin
						state_reg <= PPPC_ST_RECOVER;
					end else if (opts_i.auto_update && programmed_i && image_valid_i
						&& ver_newer(image_ver_i, design_ver_o)) begin
						state_reg <= PPPC_ST_UPDATE;
					end else begin
						state_reg <= PPPC_ST_IDLE;
					end
				end
				PPPC_ST_UPDATE: state_reg <= PPPC_ST_IDLE;
				PPPC_ST_RECOVER: state_reg <= PPPC_ST_IDLE;
				PPPC_ST_IDLE: state_reg <= PPPC_ST_IDLE;
				default: state_reg <= PPPC_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			update_start_o <= 1'b0;
			recover_start_o <= 1'b0;
		end else begin
			update_start_o <= (state_reg == PPPC_ST_DECIDE) && !(recovery_eff && prog_interrupted_i)
				&& opts_i.auto_update && programmed_i && image_valid_i
				&& ver_newer(image_ver_i, design_ver_o);
			recover_start_o <= (state_reg == PPPC_ST_DECIDE) && recovery_eff && prog_interrupted_i;
		end
	end

	// Gates are latched once at the end of settling and held until power cycles
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			gate_o <= '{jtag_en: 1'b1, fabric_ewv_en: 1'b1, probe_en: 1'b1, fabric_read_en: 1'b1,
				suspend: 1'b0};
			decided_o <= 1'b0;
		end else if (state_reg == PPPC_ST_SETTLE && settle_reg == 8'(SETTLE_CYC - 1)) begin
			decided_o <= 1'b1;
			gate_o.suspend <= opts_i.suspend && !tr_sync_reg;
			gate_o.jtag_en <= !((opts_i.jtag_dis || opts_i.suspend) && !tr_sync_reg);
			// Sub-options only act while JTAG itself is not configured off
			gate_o.fabric_ewv_en <= !(!opts_i.jtag_dis && opts_i.fabric_dis && !tr_sync_reg);
			gate_o.probe_en <= !(!opts_i.jtag_dis && opts_i.probe_dis && !tr_sync_reg);
			gate_o.fabric_read_en <= !(!opts_i.jtag_dis && opts_i.digest_dis && !tr_sync_reg);
		end
	end

	// Image fetch clock enable divider
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			div_cnt_reg <= 8'h00;
			spi_clk_en_o <= 1'b0;
		end else if (div_cnt_reg >= rate_div(spi_rate_sel_i) - 8'h01) begin
			div_cnt_reg <= 8'h00;
			spi_clk_en_o <= 1'b1;
		end else begin
			div_cnt_reg <= div_cnt_reg + 8'h01;
			spi_clk_en_o <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			spi_o <= '{spi_clock_polarity: 1'b0, spi_clock_phase: 1'b0, spi_select_behaviour: SEL_BEHAVIOUR,
				divisor: DIV_1M00};
		end else begin
			spi_o.spi_clock_polarity <= spi_clock_polarity_i;
			spi_o.spi_clock_phase <= spi_clock_phase_i;
			spi_o.spi_select_behaviour <= SEL_BEHAVIOUR;
			spi_o.divisor <= rate_div(spi_rate_sel_i);
		end
	end

	// Programming request acceptance and stored identity
	logic req_ok;
	always_comb begin
		req_ok = gate_o.jtag_en && gate_o.fabric_ewv_en && !gate_o.suspend;
		if (otp_locked_reg) begin
			req_ok = 1'b0;
		end
		if (opts_i.floor_en && !opts_i.floor_bypass && !ver_newer(prog_ver_i, floor_ver_i)) begin
			req_ok = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			prog_accept_o <= 1'b0;
			prog_reject_o <= 1'b0;
		end else begin
			prog_accept_o <= prog_req_i && req_ok;
			prog_reject_o <= prog_req_i && !req_ok;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			otp_locked_reg <= 1'b0;
		end else if (programmed_i && opts_i.otp) begin
			otp_locked_reg <= 1'b1;
		end
	end

	// Stored values live in nonvolatile cells in silicon; here they survive only until reset
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			design_ver_o <= VER_RST;
			signature_o <= SIG_RST;
			sec_locked_o <= 1'b0;
		end else if (prog_req_i && req_ok && !prog_erase_i) begin
			design_ver_o <= prog_ver_i;
			if (prog_master_i) begin
				signature_o <= prog_sig_i;
				sec_locked_o <= prog_sec_i;
			end
		end
	end
endmodule

// ### design/pppc_pkg.sv
// Package for the power-up program policy controller
// Overview of operation
// - Stored design version is 16 bits
// - Stored user signature is 32 bits
// - Auto update only if programmed and newer
// - Auto update forces recovery enabled
// - Recovery reprograms after interrupted programming
// - Image fetch clock has eight rates
// - Polarity and phase bits set SPI mode
// - Select behaviour bit fixed at one
// - Only master image alters security settings
// - One-time mode rejects erase and reprogram
// - Suspend on low test reset when enabled
// - Suspend also disables JTAG by default
// - JTAG disabled on low test reset option
// - JTAG disabled makes fabric, probe and digest options moot
// - Fabric protect blocks erase write verify
// - Probe protect blocks probe access
// - Digest protect blocks all fabric reads
// - Protection options default to cleared
// - SPI programming disable has no effect
// - Floor protection needs version above floor
package pppc_pkg;
	localparam int VER_W = 16;
	localparam int SIG_W = 32;
	localparam logic [VER_W-1:0] VER_RST = 16'h0000;
	localparam logic [SIG_W-1:0] SIG_RST = 32'h0000_0000;
	localparam logic SEL_BEHAVIOUR = 1'b1;
	// Sys clock 125 MHz; divisors give nearest achievable image fetch rates
	localparam int CLK_HZ = 125_000_000;
	localparam logic [7:0] DIV_1M00 = 8'h7D;
	localparam logic [7:0] DIV_2M08 = 8'h3C;
	localparam logic [7:0] DIV_3M13 = 8'h28;
	localparam logic [7:0] DIV_4M16 = 8'h1E;
	localparam logic [7:0] DIV_5M00 = 8'h19;
	localparam logic [7:0] DIV_6M25 = 8'h14;
	localparam logic [7:0] DIV_8M30 = 8'h0F;
	localparam logic [7:0] DIV_12M5 = 8'h0A;
	// Power-up settle delay before test reset is sampled
	localparam int SETTLE_NS = 64;
	localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	typedef enum logic [2:0] {
		PPPC_ST_SETTLE = 3'b000,
		PPPC_ST_DECIDE = 3'b001,
		PPPC_ST_UPDATE = 3'b010,
		PPPC_ST_RECOVER = 3'b011,
		PPPC_ST_IDLE = 3'b100
	} pppc_state_e;
	typedef struct packed {
		logic auto_update;
		logic recovery;
		logic otp;
		logic suspend;
		logic jtag_dis;
		logic fabric_dis;
		logic probe_dis;
		logic digest_dis;
		logic spi_dis;
		logic floor_en;
		logic floor_bypass;
	} pppc_opts_s;
	typedef struct packed {
		logic jtag_en;
		logic fabric_ewv_en;
		logic probe_en;
		logic fabric_read_en;
		logic suspend;
	} pppc_gate_s;
	typedef struct packed {
		logic spi_clock_polarity;
		logic spi_clock_phase;
		logic spi_select_behaviour;
		logic [7:0] divisor;
	} pppc_spi_s;
endpackage

// ### verification/pppc_ctrl_sva.sv
// Assertion checker for the program policy controller
`timescale 1ns/1ps
module pppc_ctrl_sva import pppc_pkg::*; (
	// Inputs
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire pppc_opts_s opts_i,
	input wire logic programmed_i,
	input wire logic prog_interrupted_i,
	input wire logic [15:0] floor_ver_i,
	input wire logic [15:0] image_ver_i,
	input wire logic prog_req_i,
	input wire logic [15:0] prog_ver_i,
	// Outputs
	input wire logic [15:0] design_ver_o,
	input wire pppc_gate_s gate_o,
	input wire pppc_spi_s spi_o,
	input wire logic update_start_o,
	input wire logic recover_start_o,
	input wire logic prog_reject_o,
	input wire logic decided_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	property p_sel; spi_o.spi_select_behaviour; endproperty
	a_sel: assert property (p_sel) else $error("select bit low");
	property p_dec; $fell(rst_i) |-> ##[7:9] decided_o; endproperty
	a_dec: assert property (p_dec) else $error("no decision");
	property p_hold; decided_o && $past(decided_o) |-> $stable(gate_o); endproperty
	a_hold: assert property (p_hold) else $error("gates moved");
	property p_susp; gate_o.suspend |-> !gate_o.jtag_en; endproperty
	a_susp: assert property (p_susp) else $error("jtag on in suspend");
	property p_upd; update_start_o |-> opts_i.auto_update && programmed_i && image_ver_i > design_ver_o; endproperty
	a_upd: assert property (p_upd) else $error("bad update");
	property p_rec; recover_start_o |-> (opts_i.recovery || opts_i.auto_update) && prog_interrupted_i; endproperty
	a_rec: assert property (p_rec) else $error("bad recovery");
	property p_otp; decided_o && prog_req_i && $past(opts_i.otp && programmed_i) |=> prog_reject_o; endproperty
	a_otp: assert property (p_otp) else $error("otp not refused");
	property p_flr; prog_req_i && opts_i.floor_en && !opts_i.floor_bypass && prog_ver_i <= floor_ver_i |=> prog_reject_o;
	endproperty
	a_flr: assert property (p_flr) else $error("floor not refused");
endmodule
bind pppc_ctrl pppc_ctrl_sva u_sva (.*);

// ### verification/pppc_flash_model.sv
// SPI image flash model holding the update image header
`timescale 1ns/1ps
module pppc_flash_model (
	// Clock and image version to present
	input wire logic clk_i,
	input wire logic [15:0] ver_i,
	// Header seen by the controller
	output logic [15:0] image_ver_o,
	output logic image_valid_o
);
	always_ff @(posedge clk_i) begin
		image_ver_o <= ver_i;
		image_valid_o <= 1'b1;
	end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the program policy controller
`timescale 1ns/1ps
module testbench;
	import pppc_pkg::*;
	logic sys_clk_i = 0, rst_i = 1, spi_clock_polarity_i = 0, spi_clock_phase_i = 0, test_reset_i = 0;
	logic programmed_i = 0, prog_interrupted_i = 0, prog_req_i = 0, prog_master_i = 0, prog_erase_i = 0;
	logic prog_sec_i = 0, image_valid_i, spi_clk_en_o, sec_locked_o, update_start_o, recover_start_o;
	logic prog_accept_o, prog_reject_o, decided_o;
	logic [2:0] spi_rate_sel_i = 0;
	logic [15:0] floor_ver_i = 0, prog_ver_i = 0, img_ver = 0, image_ver_i, design_ver_o;
	logic [31:0] prog_sig_i = 0, signature_o;
	pppc_opts_s opts_i = 0;
	pppc_gate_s gate_o;
	pppc_spi_s spi_o;
	int failures = 0, cmp_count = 0, ups, recs;
	pppc_ctrl uut (.*);
	pppc_flash_model flash (.clk_i(sys_clk_i), .ver_i(img_ver), .image_ver_o(image_ver_i), .image_valid_o(image_valid_i));
	always #4 sys_clk_i = ~sys_clk_i;
	task automatic chk(input logic [63:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Power cycle, counting start pulses over the fixed decision window
	task automatic pwr(input pppc_opts_s o, input logic t);
		@(posedge sys_clk_i);
		rst_i <= 1;
		opts_i <= o;
		test_reset_i <= t;
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 0;
		ups = 0;
		recs = 0;
		repeat (16) begin
			@(posedge sys_clk_i);
			ups += update_start_o;
			recs += recover_start_o;
		end
		chk(decided_o, 1);
	endtask
	task automatic rq(input logic m, e, input logic [15:0] v, input logic a);
		@(posedge sys_clk_i);
		prog_req_i <= 1;
		prog_master_i <= m;
		prog_erase_i <= e;
		prog_ver_i <= v;
		prog_sig_i <= {v, v};
		prog_sec_i <= m;
		@(posedge sys_clk_i);
		prog_req_i <= 0;
		@(posedge sys_clk_i);
		chk({prog_accept_o, prog_reject_o}, {a, !a});
	endtask
	task automatic t_gates;
		pppc_opts_s o[8] = '{11'h000, 11'h080, 11'h040, 11'h020, 11'h010, 11'h008, 11'h004, 11'h060};
		pppc_gate_s g[8] = '{5'h1E, 5'h0F, 5'h0E, 5'h16, 5'h1A, 5'h1C, 5'h1E, 5'h0E};
		for (int i = 0; i < 16; i++) begin
			pwr(o[i / 2], i[0]);
			chk(gate_o, i[0] ? 5'h1E : g[i / 2]);
		end
	endtask
	task automatic t_spi;
		logic [7:0] d[8] = '{DIV_1M00, DIV_2M08, DIV_3M13, DIV_4M16, DIV_5M00, DIV_6M25, DIV_8M30, DIV_12M5};
		int n;
		for (int i = 0; i < 8; i++) begin
			spi_rate_sel_i <= i[2:0];
			spi_clock_polarity_i <= i[0];
			spi_clock_phase_i <= i[1];
			pwr(0, 1);
			chk(spi_o, {i[0], i[1], 1'b1, d[i]});
			// Period between enable pulses must equal the selected divisor
			n = 0;
			do @(posedge sys_clk_i); while (!spi_clk_en_o);
			do begin
				@(posedge sys_clk_i);
				n++;
			end while (!spi_clk_en_o);
			chk(n, d[i]);
		end
	endtask
	task automatic au(input pppc_opts_s o, input logic p, n, input logic [15:0] v, input int u, r);
		programmed_i <= p;
		prog_interrupted_i <= n;
		img_ver <= v;
		pwr(o, 1);
		chk({ups, recs}, {u, r});
	endtask
	task automatic t_prog;
		programmed_i <= 0;
		prog_interrupted_i <= 0;
		floor_ver_i <= 16'h0010;
		pwr(0, 1);
		rq(1, 0, 16'h0005, 1);
		chk({design_ver_o, signature_o, sec_locked_o}, {16'h0005, 32'h0005_0005, 1'b1});
		rq(0, 0, 16'hFFFF, 1);
		rq(0, 1, 16'h0009, 1);
		chk({design_ver_o, signature_o, sec_locked_o}, {16'hFFFF, 32'h0005_0005, 1'b1});
		pwr(11'h002, 1);
		rq(1, 0, 16'h0010, 0);
		rq(1, 0, 16'h0011, 1);
		pwr(11'h003, 1);
		rq(1, 0, 16'h0005, 1);
		programmed_i <= 1;
		pwr(11'h100, 1);
		rq(0, 1, 16'h0020, 0);
		rq(1, 0, 16'h0020, 0);
		pwr(11'h020, 0);
		rq(1, 0, 16'h0020, 0);
	endtask
	task end_of_test;
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		t_gates();
		t_spi();
		au(11'h400, 1, 0, 16'h0001, 1, 0);
		au(11'h400, 1, 0, 16'hFFFF, 1, 0);
		au(11'h400, 1, 0, 16'h0000, 0, 0);
		au(11'h400, 0, 0, 16'h0005, 0, 0);
		au(11'h000, 1, 0, 16'h0005, 0, 0);
		au(11'h200, 0, 1, 16'h0000, 0, 1);
		au(11'h000, 0, 1, 16'h0000, 0, 0);
		au(11'h400, 1, 1, 16'h0005, 0, 1);
		t_prog();
		end_of_test();
	end
	// Whole run is about 1,950 cycles; this margin only trips on a hang
	initial begin
		#50us;
		failures++;
		end_of_test();
	end
endmodule
